// ===== kel_defines.svh
// Purpose: Constants for the keyless entry lock control block
// Assumes: 100 MHz pclk
// Notes:   Times in ms with derived cycle counts
`ifndef KEL_DEFINES_SVH
`define KEL_DEFINES_SVH
`define KEL_CLK_MHZ        100
`define KEL_FOREIGN_LIMIT  256
`define KEL_RECOVER_COUNT  5
`define KEL_RELOCK_MS      30000
`define KEL_RETRY_MS       1000
`define KEL_FLASH_MS       250
`define KEL_MOTOR_MS       200
`define KEL_MS_CYCLES(ms)  (32'(64'(ms) * 64'd1000 * `KEL_CLK_MHZ))
// APB register byte offsets
`define KEL_REG_CTRL       12'h000
`define KEL_REG_STAT       12'h004
`define KEL_REG_IRQ_STAT   12'h008
`define KEL_REG_IRQ_CLR    12'h00c
`define KEL_REG_IRQ_EN     12'h010
`define KEL_REG_CODE       12'h014
`define KEL_REG_FCOUNT     12'h018
// Interrupt status bit positions
`define KEL_IRQ_LOCKED     0
`define KEL_IRQ_UNLOCKED   1
`define KEL_IRQ_LOCKOUT    2
`define KEL_IRQ_RECOVER    3
`define KEL_IRQ_RELOCK     4
`define KEL_IRQ_W          5
// Control bit: enable keyless function
`define KEL_CTRL_ENABLE    0
`define KEL_CTRL_RESET     32'h0000_0001
`endif

// ===== kel_pkg.sv
// Purpose: Types for the keyless entry lock control block
// Assumes: Used with kel_defines.svh
// Notes:   Function codes and controller states
package kel_pkg;
  typedef enum logic [1:0] {
    KEL_FN_NONE   = 2'h0,
    KEL_FN_LOCK   = 2'h1,
    KEL_FN_UNLOCK = 2'h2
  } kel_fn_t;
  typedef enum logic [4:0] {
    KEL_ST_IDLE  = 5'h01,
    KEL_ST_DRIVE = 5'h02,
    KEL_ST_CHECK = 5'h04,
    KEL_ST_WAIT  = 5'h08,
    KEL_ST_FLASH = 5'h10
  } kel_state_t;
endpackage

// ===== kel_link_if.sv
// Purpose: Link between meter computer end and body controller end
// Assumes: One clock, pclk
// Notes:   Request is a one-cycle strobe with function and id
`timescale 1ns/1ps
interface kel_link_if #(parameter int ID_W = 32) (input wire logic pclk);
  import kel_pkg::*;
  logic            req;
  kel_fn_t         fn;
  logic [ID_W-1:0] id;
  logic            door_open;
  logic            key_in;
  modport meter (output req, output fn, output id,
                 output door_open, output key_in);
  modport body  (input req, input fn, input id,
                 input door_open, input key_in);
endinterface

// ===== kel_meter_end.sv
// Purpose: Meter computer end, relays receiver requests and door state
// Assumes: Inputs synchronous to pclk
// Notes:   One-cycle relay delay
`timescale 1ns/1ps
module kel_meter_end
  import kel_pkg::*;
#(
  parameter int ID_W = 32
) (
  // Clock and reset
  input  wire logic      pclk,
  input  wire logic      presetn,
  // Receiver side
  input  wire logic      rx_valid,
  input  wire kel_fn_t   rx_fn,
  input  wire logic [ID_W-1:0] rx_id,
  // Switches
  input  wire logic      courtesy_sw,
  input  wire logic      key_sw,
  // Link
  kel_link_if.meter      link
);
  // Forward each request and the switch states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.req       <= 1'b0;
      link.fn        <= KEL_FN_NONE;
      link.id        <= '0;
      link.door_open <= 1'b0;
      link.key_in    <= 1'b0;
    end else begin
      link.req       <= rx_valid && (rx_fn != KEL_FN_NONE);
      link.fn        <= rx_fn;
      link.id        <= rx_id;
      link.door_open <= courtesy_sw;
      link.key_in    <= key_sw;
    end
  end
endmodule // kel_meter_end

// ===== kel_body_end.sv
// Purpose: Body controller end of the keyless entry lock control
// Assumes: Inputs synchronous to pclk; APB slave with zero wait states
// Notes:   Rules listed below
// Behaviour
// - Lock out unlocks after 256 foreign attempts
// - Five registered unlocks restore normal operation
// - Transmitter sends id and function per press
// - Act only on matching id, lock/unlock
// - Meter relays requests over the link
// - Drive all door motors together
// - Lock one direction, unlock opposite
// - Auto-relock after 30 s unlocked
// - Cancel relock on open, lock, key, ignition
// - Ignore requests while door open or key
// - Retry command after 1 s if unconfirmed
// - Flash hazards once lock, twice unlock
// - Only driver door reports lock position
// - Courtesy switch high means door open
// - Meter sends door and key state
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "kel_defines.svh"
module kel_body_end
  import kel_pkg::*;
#(
  parameter int ID_W       = 32,
  parameter int DOORS      = 5,
  parameter int unsigned RELOCK_CYC = `KEL_MS_CYCLES(`KEL_RELOCK_MS),
  parameter int unsigned RETRY_CYC  = `KEL_MS_CYCLES(`KEL_RETRY_MS),
  parameter int unsigned FLASH_CYC  = `KEL_MS_CYCLES(`KEL_FLASH_MS),
  parameter int unsigned MOTOR_CYC  = `KEL_MS_CYCLES(`KEL_MOTOR_MS)
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Link from meter computer
  kel_link_if.body              link,
  // Vehicle inputs
  input  wire logic             drv_locked,
  input  wire logic             ign_on,
  // Actuators and interrupt
  output logic      [DOORS-1:0] motor_lock,
  output logic      [DOORS-1:0] motor_unlock,
  output logic                  flasher,
  output logic                  irq
);
  localparam int CW = 32;
  kel_state_t            st_q;
  logic [CW-1:0]         tmr_q, rlk_q;
  logic                  rlk_arm_q, retried_q, lockout_q;
  kel_fn_t               cmd_q;
  logic                  kl_q;      // Command came from the transmitter
  logic [2:0]            blinks_q;
  logic [8:0]            fcnt_q;
  logic [2:0]            rcnt_q;
  logic [31:0]           ctrl_q;
  logic [ID_W-1:0]       code_q;
  logic [`KEL_IRQ_W-1:0] ist_q, ien_q, iev;
  // Decode of a strobed request
  function automatic logic is_fn(input kel_fn_t f, input kel_fn_t want);
    return link.req && (f == want);
  endfunction
  logic wr, rd, id_ok, inhibit, kl_lock, kl_unlock, foreign;
  logic confirmed;
  assign wr        = psel && penable && pwrite;
  assign rd        = psel && !penable && !pwrite;
  assign id_ok     = (link.id == code_q);
  assign inhibit   = link.door_open || link.key_in
                     || !ctrl_q[`KEL_CTRL_ENABLE];
  assign foreign   = is_fn(link.fn, KEL_FN_UNLOCK) && !id_ok && !inhibit;
  assign kl_lock   = is_fn(link.fn, KEL_FN_LOCK) && id_ok && !inhibit;
  assign kl_unlock = is_fn(link.fn, KEL_FN_UNLOCK) && id_ok && !inhibit
                     && (!lockout_q || rcnt_q == 3'(`KEL_RECOVER_COUNT - 1));
  // driver door switch is the sole position report
  assign confirmed = (cmd_q == KEL_FN_LOCK) ? drv_locked : !drv_locked;
  // Lockout counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt_q    <= '0;
      rcnt_q    <= '0;
      lockout_q <= 1'b0;
    end else if (lockout_q) begin
      if (is_fn(link.fn, KEL_FN_UNLOCK) && id_ok && !inhibit) begin
        if (rcnt_q == 3'(`KEL_RECOVER_COUNT - 1)) begin
          lockout_q <= 1'b0;
          rcnt_q    <= '0;
          fcnt_q    <= '0;
        end else begin
          rcnt_q <= rcnt_q + 3'h1;
        end
      end
    end else if (foreign) begin
      if (fcnt_q == 9'(`KEL_FOREIGN_LIMIT - 1)) begin
        lockout_q <= 1'b1;
        fcnt_q    <= 9'(`KEL_FOREIGN_LIMIT);
      end else begin
        fcnt_q <= fcnt_q + 9'h1;
      end
    end
  end
  // Command sequencer: drive, check, retry, answer back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= KEL_ST_IDLE;
      tmr_q     <= '0;
      cmd_q     <= KEL_FN_NONE;
      kl_q      <= 1'b0;
      retried_q <= 1'b0;
      blinks_q  <= '0;
      flasher   <= 1'b0;
    end else begin
      case (st_q)
        KEL_ST_IDLE: begin
          tmr_q <= '0;
          if (kl_lock || kl_unlock) begin
            cmd_q     <= kl_lock ? KEL_FN_LOCK : KEL_FN_UNLOCK;
            kl_q      <= 1'b1;
            retried_q <= 1'b0; // Retry flag stays in status until now
            st_q      <= KEL_ST_DRIVE;
          end else if (rlk_arm_q && rlk_q == CW'(RELOCK_CYC - 1)) begin
            cmd_q     <= KEL_FN_LOCK;
            kl_q      <= 1'b0;
            retried_q <= 1'b0;
            st_q      <= KEL_ST_DRIVE;
          end
        end
        KEL_ST_DRIVE: begin
          tmr_q <= tmr_q + 1'b1;
          if (tmr_q == CW'(MOTOR_CYC - 1)) begin
            tmr_q <= '0;
            st_q  <= KEL_ST_CHECK;
          end
        end
        KEL_ST_CHECK: begin
          if (confirmed) begin
            blinks_q <= (cmd_q == KEL_FN_LOCK) ? 3'h1 : 3'h2;
            st_q     <= KEL_ST_FLASH;
          end else if (!retried_q) begin
            st_q <= KEL_ST_WAIT;
          end else begin
            st_q <= KEL_ST_IDLE;
          end
        end
        KEL_ST_WAIT: begin
          tmr_q <= tmr_q + 1'b1;
          if (tmr_q == CW'(RETRY_CYC - 1)) begin
            tmr_q     <= '0;
            retried_q <= 1'b1;
            st_q      <= KEL_ST_DRIVE;
          end
        end
        KEL_ST_FLASH: begin
          tmr_q <= tmr_q + 1'b1;
          if (tmr_q == CW'(FLASH_CYC - 1)) begin
            tmr_q   <= '0;
            flasher <= !flasher;
            if (flasher) begin
              blinks_q <= blinks_q - 3'h1;
              if (blinks_q == 3'h1) st_q <= KEL_ST_IDLE;
            end
          end
        end
        default: st_q <= KEL_ST_IDLE;
      endcase
    end
  end
  // Motor drive: all doors together, opposite senses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_lock   <= '0;
      motor_unlock <= '0;
    end else begin
      motor_lock   <= {DOORS{st_q == KEL_ST_DRIVE && cmd_q == KEL_FN_LOCK}};
      motor_unlock <= {DOORS{st_q == KEL_ST_DRIVE && cmd_q == KEL_FN_UNLOCK}};
    end
  end
  // Auto-relock timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rlk_arm_q <= 1'b0;
      rlk_q     <= '0;
    end else if (link.door_open || link.key_in || ign_on
                 || (drv_locked && st_q == KEL_ST_IDLE)) begin
      rlk_arm_q <= 1'b0;
      rlk_q     <= '0;
    end else if (st_q == KEL_ST_FLASH && kl_q && cmd_q == KEL_FN_UNLOCK) begin
      rlk_arm_q <= 1'b1;
      rlk_q     <= '0;
    end else if (rlk_arm_q) begin
      if (rlk_q == CW'(RELOCK_CYC - 1) && st_q == KEL_ST_IDLE) begin
        rlk_arm_q <= 1'b0;
      end
      rlk_q <= rlk_q + 1'b1;
    end
  end

  // Interrupt events
  always_comb begin
    iev = '0;
    iev[`KEL_IRQ_LOCKED]   = st_q == KEL_ST_CHECK && confirmed
                             && cmd_q == KEL_FN_LOCK;
    iev[`KEL_IRQ_UNLOCKED] = st_q == KEL_ST_CHECK && confirmed
                             && cmd_q == KEL_FN_UNLOCK;
    iev[`KEL_IRQ_LOCKOUT]  = foreign && !lockout_q
                             && fcnt_q == 9'(`KEL_FOREIGN_LIMIT - 1);
    iev[`KEL_IRQ_RECOVER]  = lockout_q && kl_unlock;
    iev[`KEL_IRQ_RELOCK]   = rlk_arm_q && st_q == KEL_ST_IDLE
                             && rlk_q == CW'(RELOCK_CYC - 1);
  end

  // Sticky status: set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= '0;
    end else begin
      ist_q <= (ist_q & ~((wr && paddr == `KEL_REG_IRQ_CLR)
                ? pwdata[`KEL_IRQ_W-1:0] : '0)) | iev;
    end
  end

  // Writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `KEL_CTRL_RESET;
      ien_q  <= '0;
      code_q <= '0;
    end else if (wr) begin
      case (paddr)
        `KEL_REG_CTRL:   ctrl_q <= pwdata;
        `KEL_REG_IRQ_EN: ien_q  <= pwdata[`KEL_IRQ_W-1:0];
        `KEL_REG_CODE:   code_q <= pwdata[ID_W-1:0];
        default: ;
      endcase
    end
  end

  // APB read data, error and interrupt output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b1;
      pslverr <= 1'b0;
      irq     <= 1'b0;
    end else begin
      pready  <= 1'b1;
      irq     <= |(ist_q & ien_q);
      pslverr <= psel && !penable && !(paddr inside {`KEL_REG_CTRL,
                 `KEL_REG_STAT, `KEL_REG_IRQ_STAT, `KEL_REG_IRQ_CLR,
                 `KEL_REG_IRQ_EN, `KEL_REG_CODE, `KEL_REG_FCOUNT});
      if (rd) begin
        case (paddr)
          `KEL_REG_CTRL:     prdata <= ctrl_q;
          `KEL_REG_STAT:     prdata <= {24'h0, st_q, retried_q,
                                        rlk_arm_q, lockout_q};
          `KEL_REG_IRQ_STAT: prdata <= 32'(ist_q);
          `KEL_REG_IRQ_EN:   prdata <= 32'(ien_q);
          `KEL_REG_CODE:     prdata <= 32'(code_q);
          `KEL_REG_FCOUNT:   prdata <= {20'h0, rcnt_q, fcnt_q};
          default:           prdata <= '0;
        endcase
      end
    end
  end
endmodule // kel_body_end

// ===== kel_link_properties.sv
// Purpose: Link and actuator checks for keyless lock control
// Assumes: One pclk domain, presetn active low
// Notes:   Takes meter inputs, link signals and body actuators
`timescale 1ns/1ps
module kel_link_properties
  import kel_pkg::*;
#(
  parameter int DOORS = 5
) (
  // Clock and reset
  input wire logic             pclk,
  input wire logic             presetn,
  // Receiver and switches
  input wire logic             rx_valid,
  input wire kel_fn_t          rx_fn,
  input wire logic [31:0]      rx_id,
  input wire logic             courtesy_sw,
  input wire logic             key_sw,
  // Link
  input wire logic             req,
  input wire kel_fn_t          fn,
  input wire logic [31:0]      id,
  input wire logic             door_open,
  input wire logic             key_in,
  // Actuators
  input wire logic [DOORS-1:0] motor_lock,
  input wire logic [DOORS-1:0] motor_unlock,
  input wire logic             flasher
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Relay of requests and switch levels
  a_relay_one_cycle: assert property (
    rx_valid && rx_fn != KEL_FN_NONE
    |=> req && fn == $past(rx_fn) && id == $past(rx_id))
    else $error("request not relayed");
  a_req_has_cause: assert property (
    req |-> $past(rx_valid)) else $error("request without cause");
  a_door_follows_sw: assert property (
    $rose(courtesy_sw) |=> $rose(door_open)) else $error("door state");
  a_key_follows_sw: assert property (
    $rose(key_sw) |=> $rose(key_in)) else $error("key state");
  // Motors move together and one way
  a_lock_all_doors: assert property (
    |motor_lock |-> &motor_lock) else $error("partial lock");
  a_unlock_all_doors: assert property (
    |motor_unlock |-> &motor_unlock) else $error("partial unlock");
  a_motor_one_way: assert property (
    !(|motor_lock && |motor_unlock)) else $error("both directions");
  a_motor_holds_on: assert property (
    $rose(|motor_lock) |=> (|motor_lock)[*8]) else $error("short pulse");
  // Inhibit and answer back
  a_open_blocks_req: assert property (
    req && fn == KEL_FN_UNLOCK && (door_open || key_in)
    |=> (!$rose(|motor_unlock))[*4]) else $error("inhibit ignored");
  a_flash_after_motor: assert property (
    $rose(flasher) |-> !(|motor_lock) && !(|motor_unlock))
    else $error("flash during drive");
  // Main scenarios
  c_lock: cover property ($rose(|motor_lock));
  c_unlock: cover property ($rose(|motor_unlock));
  c_flash: cover property ($rose(flasher));
  c_inhibit: cover property (req && door_open);
endmodule // kel_link_properties

// ===== keyless_entry_lock_control_bench.sv
// Purpose: Self-checking bench for both ends of keyless lock control
// Assumes: Short time parameters, doors follow the motors
// Notes:   APB tasks and transmitter presses drive all tests
`timescale 1ns/1ps
`include "kel_defines.svh"
module keyless_entry_lock_control_bench;
  import kel_pkg::*;
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin \
    bad_count++; $display("ERROR %0t mismatch", $time); end end
  localparam logic [31:0] ID = 32'h0000_c35a;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        rx_valid = 0, courtesy_sw = 0, key_sw = 0, ign_on = 0;
  logic        drv_locked = 0, stuck = 0, pready, pslverr, flasher, irq;
  logic        err;
  logic [2:0]  pv = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, rx_id = 0;
  logic [4:0]  motor_lock, motor_unlock;
  kel_fn_t     rx_fn = KEL_FN_NONE;
  int          bad_count = 0, checked = 0, nl = 0, nu = 0, nf = 0;
  // Clock
  always #5 pclk = ~pclk;
  kel_link_if kel_link_if_inst (.pclk(pclk));
  kel_meter_end kel_meter_end_inst (.pclk, .presetn, .rx_valid, .rx_fn,
    .rx_id, .courtesy_sw, .key_sw, .link(kel_link_if_inst));
  kel_body_end #(.RELOCK_CYC(400), .RETRY_CYC(40), .FLASH_CYC(20),
    .MOTOR_CYC(20)) kel_body_end_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .link(kel_link_if_inst), .drv_locked, .ign_on, .motor_lock,
    .motor_unlock, .flasher, .irq);
  kel_link_properties kel_link_properties_inst (.pclk,
    .presetn, .rx_valid, .rx_fn, .rx_id, .courtesy_sw, .key_sw,
    .req(kel_link_if_inst.req), .fn(kel_link_if_inst.fn),
    .id(kel_link_if_inst.id), .door_open(kel_link_if_inst.door_open),
    .key_in(kel_link_if_inst.key_in), .motor_lock, .motor_unlock,
    .flasher);
  // Driver door switch follows the motors unless stuck; rise counters
  always @(posedge pclk) begin
    if (presetn) begin
      pv <= {motor_lock[0], motor_unlock[0], flasher};
      if (!stuck && motor_lock[0]) drv_locked <= 1'b1;
      if (!stuck && motor_unlock[0]) drv_locked <= 1'b0;
      nl <= nl + int'(motor_lock[0] && !pv[2]);
      nu <= nu + int'(motor_unlock[0] && !pv[1]);
      nf <= nf + int'(flasher && !pv[0]);
    end
  end
  // One APB transfer, read data and error taken when pready is high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One transmitter press as seen at the receiver
  task automatic press(input kel_fn_t f, input logic [31:0] i);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_fn <= f;
    rx_id <= i;
    @(posedge pclk);
    rx_valid <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Poll the sequencer state until it is back in idle
  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, `KEL_REG_STAT, 32'h0);
      n++;
    end while (rd[7:3] !== 5'h01 && n < 500);
    `CHK(rd[7:3], 5'h01)
  endtask
  task automatic end_sim();
    if (bad_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    #500us;
    bad_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    run(12);
    presetn <= 1'b1;
    apb(1'b0, `KEL_REG_CTRL, 32'h0);
    `CHK(rd, `KEL_CTRL_RESET)
    apb(1'b0, 12'h0fc, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, `KEL_REG_CODE, ID);
    apb(1'b1, `KEL_REG_IRQ_EN, 32'h1);
    press(KEL_FN_LOCK, ~ID);
    run(40);
    `CHK(nl, 0)
    press(KEL_FN_LOCK, ID);
    idle();
    `CHK({nl, nf, 1'b1}, {32'd1, 32'd1, irq})
    apb(1'b1, `KEL_REG_IRQ_CLR, 32'h1f);
    run(3);
    `CHK(irq, 1'b0)
    for (int k = 0; k < 2; k++) begin
      courtesy_sw <= (k == 0);
      key_sw <= (k == 1);
      press(KEL_FN_UNLOCK, ID);
      run(40);
      `CHK(nu, 0)
    end
    courtesy_sw <= 1'b0;
    key_sw <= 1'b0;
    press(KEL_FN_UNLOCK, ID);
    idle();
    `CHK({nu, nf}, {32'd1, 32'd3})
    apb(1'b0, `KEL_REG_IRQ_STAT, 32'h0);
    `CHK({rd[1], irq}, 2'b10)
    apb(1'b1, `KEL_REG_IRQ_CLR, 32'h1f);
    run(450);
    `CHK(nl, 2)
    for (int k = 0; k < 3; k++) begin
      idle();
      press(KEL_FN_UNLOCK, ID);
      idle();
      courtesy_sw <= (k == 0);
      key_sw <= (k == 1);
      ign_on <= (k == 2);
      run(4);
      courtesy_sw <= 1'b0;
      key_sw <= 1'b0;
      ign_on <= 1'b0;
      run(450);
      `CHK(nl, 2)
    end
    stuck <= 1'b1;
    press(KEL_FN_LOCK, ID);
    idle();
    `CHK({nl, rd[2]}, {32'd4, 1'b1})
    stuck <= 1'b0;
    press(KEL_FN_LOCK, ID);
    idle();
    for (int k = 0; k < 256; k++) press(KEL_FN_UNLOCK, ~ID);
    apb(1'b0, `KEL_REG_STAT, 32'h0);
    `CHK(rd[0], 1'b1)
    apb(1'b0, `KEL_REG_FCOUNT, 32'h0);
    `CHK(rd[8:0], 9'h100)
    for (int k = 0; k < 5; k++) begin
      press(KEL_FN_UNLOCK, ID);
      idle();
      `CHK(nu, 4 + int'(k == 4))
    end
    `CHK(rd[0], 1'b0)
    apb(1'b0, `KEL_REG_FCOUNT, 32'h0);
    `CHK(rd[11:0], 12'h000)
    end_sim();
  end
endmodule // keyless_entry_lock_control_bench
